/* File: design/aic_pkg.sv */
// constants shared by the interface configuration register group
package aic_pkg;

  // serial instruction layout: one read flag then the register address
  localparam int          ADDR_W        = 15;
  localparam int          INSTR_W       = 16;
  localparam int          BYTE_W        = 8;
  localparam int          RW_POS        = 15;
  localparam logic [3:0]  INSTR_LAST    = 4'hf;
  localparam logic [3:0]  BYTE_LAST     = 4'h7;
  localparam logic [3:0]  CNT_ZERO      = 4'h0;
  localparam logic [14:0] ADDR_STEP     = 15'h0001;

  // register offsets
  localparam logic [14:0] OFS_PRI       = 15'h0000;
  localparam logic [14:0] OFS_SEC       = 15'h0001;
  localparam logic [14:0] OFS_PWR       = 15'h0002;
  localparam logic [14:0] OFS_FAMILY    = 15'h0003;
  localparam logic [14:0] OFS_PART_LO   = 15'h0004;
  localparam logic [14:0] OFS_PART_HI   = 15'h0005;
  localparam logic [14:0] OFS_GRADE     = 15'h0006;
  localparam logic [14:0] OFS_TEST      = 15'h000a;

  // field positions
  localparam int          SRST_UP_POS   = 7;
  localparam int          ADDR_DIR_POS  = 5;
  localparam int          PIN_GATE_POS  = 4;
  localparam int          SRST_LO_POS   = 0;
  localparam int          ONE_INSTR_POS = 7;
  localparam int          STALL_POS     = 6;
  localparam int          COMPACT_POS   = 3;

  // reset and fixed values
  localparam logic [7:0]  PRI_RST       = 8'h10;
  localparam logic [7:0]  BYTE_ZERO     = 8'h00;
  localparam logic [1:0]  PWR_NORMAL    = 2'h0;
  localparam logic [1:0]  PWR_SHUTDOWN  = 2'h3;
  localparam logic        ADDR_DIR_VAL  = 1'b0;
  localparam logic        PIN_GATE_VAL  = 1'b1;
  localparam logic        COMPACT_VAL   = 1'b0;
  localparam logic [2:0]  SYNC_RST      = 3'h0;
  localparam logic [2:0]  CS_SYNC_RST   = 3'h7;

endpackage

/* File: design/aic_config_regs.sv */
// interface configuration and identification registers behind a serial port
`timescale 1ns/1ps
module aic_config_regs
  import aic_pkg::*;
#(
  parameter logic [3:0]  FAMILY_CODE = 4'h5,    // arbitrary value
  parameter logic [15:0] PART_CODE   = 16'h3c5a, // arbitrary value
  parameter logic [4:0]  GRADE_CODE  = 5'h0b,   // arbitrary value
  parameter logic [2:0]  REV_CODE    = 3'h6     // arbitrary value
)(
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       sclkPin,
  input  wire logic       csPin_n,
  input  wire logic       mosiPin,
  input  wire logic       cfgMode,
  output logic            misoOut,
  output logic            misoOe,
  output logic            softResetPulse,
  output logic [1:0]      powerState,
  output logic            shutdown
);

  typedef enum logic [1:0] {ST_IDLE, ST_INSTR, ST_DATA, ST_HOLD} aic_state_t;

  aic_state_t        state;
  logic [2:0]        sclkSync;
  logic [2:0]        csSync;
  logic [2:0]        mosiSync;
  logic              sclkLevel;
  logic [3:0]        bitCnt;
  logic [INSTR_W-2:0] shiftIn;
  logic [ADDR_W-1:0] addr;
  logic              isRead;
  logic [7:0]        readShift;
  logic              resetUpper;
  logic              resetLower;
  logic              oneInstr;
  logic              stallHold;
  logic [7:0]        testByte;

  logic              sclkRise;
  logic              sclkFall;
  logic              csAsserted;
  logic              csIdle;
  logic              mosiBit;
  logic [INSTR_W-1:0] instrWord;
  logic [7:0]        wrData;
  logic              instrDone;
  logic              byteDone;
  logic              wrEn;
  logic              softReset;
  logic [ADDR_W-1:0] next_addr;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  // read value of any register, unmapped reads zero
  function automatic logic [7:0] readByte(input logic [ADDR_W-1:0] a);
    logic [7:0] v;
    v = BYTE_ZERO;
    case (a)
      OFS_PRI: begin
        v[SRST_UP_POS]  = resetUpper;
        v[ADDR_DIR_POS] = ADDR_DIR_VAL;
        v[PIN_GATE_POS] = PIN_GATE_VAL;
        v[SRST_LO_POS]  = resetLower;
      end
      OFS_SEC: begin
        v[ONE_INSTR_POS] = oneInstr;
        v[STALL_POS]     = stallHold;
        v[COMPACT_POS]   = COMPACT_VAL;
      end
      OFS_PWR:     v[1:0] = powerState;
      OFS_FAMILY:  v[3:0] = FAMILY_CODE;
      OFS_PART_LO: v = PART_CODE[7:0];
      OFS_PART_HI: v = PART_CODE[15:8];
      OFS_GRADE:   v = {GRADE_CODE, REV_CODE};
      OFS_TEST:    v = testByte;
      default:     v = BYTE_ZERO;
    endcase
    return v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // pin synchronisers, three stages each
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sclkSync  <= SYNC_RST;
      sclkLevel <= SYNC_RST[0];
      csSync    <= CS_SYNC_RST;
      mosiSync  <= SYNC_RST;
    end else begin
      sclkSync <= {sclkSync[1:0], sclkPin};
      csSync   <= {csSync[1:0], csPin_n};
      mosiSync <= {mosiSync[1:0], mosiPin};
      if (sclkSync[1] == sclkSync[2]) begin
        sclkLevel <= sclkSync[2]; // filtered level, idle low after reset
      end
    end
  end

  // edges and chip select levels once stages two and three agree, data bit from stage three alone
  assign sclkRise   = sclkSync[1] & sclkSync[2] & ~sclkLevel;
  assign sclkFall   = ~sclkSync[1] & ~sclkSync[2] & sclkLevel;
  assign csAsserted = ~csSync[1] & ~csSync[2];
  assign csIdle     = csSync[1] & csSync[2];
  assign mosiBit    = mosiSync[2];

  // decoded transaction events
  assign instrWord = {shiftIn, mosiBit};
  assign wrData    = {shiftIn[6:0], mosiBit};
  assign instrDone = (state == ST_INSTR) && sclkRise && (bitCnt == INSTR_LAST);
  assign byteDone  = (state == ST_DATA) && sclkRise && (bitCnt == BYTE_LAST);
  assign wrEn      = byteDone && !isRead && cfgMode;
  assign softReset = wrEn && (addr == OFS_PRI)
                     && wrData[SRST_UP_POS] && wrData[SRST_LO_POS];
  assign next_addr = addr - ADDR_STEP;

  ////////////////////////////////////////////////////////////////////////////////
  // transaction sequencer
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= ST_IDLE;
    end else if (csIdle) begin
      state <= ST_IDLE;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (csAsserted) begin
            state <= cfgMode ? ST_INSTR : ST_HOLD;
          end
        end
        ST_INSTR: begin
          if (instrDone) begin
            state <= ST_DATA;
          end
        end
        ST_DATA: begin
          if (byteDone && oneInstr) begin
            state <= ST_HOLD;
          end
        end
        ST_HOLD: state <= ST_HOLD;
      endcase
    end
  end

  // bit counter and input shifter
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bitCnt  <= CNT_ZERO;
      shiftIn <= '0;
    end else if (state == ST_IDLE) begin
      bitCnt <= CNT_ZERO;
    end else if (sclkRise) begin
      shiftIn <= instrWord[INSTR_W-2:0];
      if (instrDone || byteDone) begin
        bitCnt <= CNT_ZERO;
      end else begin
        bitCnt <= bitCnt + 4'h1;
      end
    end
  end

  // address pointer, descending while streaming
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      addr   <= OFS_PRI;
      isRead <= 1'b0;
    end else if (instrDone) begin
      addr   <= instrWord[ADDR_W-1:0];
      isRead <= instrWord[RW_POS];
    end else if (byteDone) begin
      addr <= next_addr;
    end
  end

  // read data shifter, msb first, advanced on falling clock
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      readShift <= BYTE_ZERO;
    end else if (instrDone) begin
      readShift <= readByte(instrWord[ADDR_W-1:0]);
    end else if (byteDone) begin
      readShift <= readByte(next_addr);
    end else if (sclkFall && (state == ST_DATA) && (bitCnt != CNT_ZERO)) begin
      readShift <= {readShift[6:0], 1'b0};
    end
  end

  assign misoOut = readShift[7];
  assign misoOe  = (state == ST_DATA) && isRead && PIN_GATE_VAL;

  ////////////////////////////////////////////////////////////////////////////////
  // primary setup, untouched by soft reset
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      resetUpper <= PRI_RST[SRST_UP_POS];
      resetLower <= PRI_RST[SRST_LO_POS];
    end else if (wrEn && (addr == OFS_PRI)) begin
      resetUpper <= wrData[SRST_UP_POS];
      resetLower <= wrData[SRST_LO_POS];
    end
  end

  // soft reset strobe for the rest of the device
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      softResetPulse <= 1'b0;
    end else begin
      softResetPulse <= softReset;
    end
  end

  // secondary setup, power field and test byte
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      oneInstr   <= 1'b0;
      stallHold  <= 1'b0;
      powerState <= PWR_NORMAL;
      testByte   <= BYTE_ZERO;
    end else if (softReset) begin
      oneInstr   <= 1'b0;
      stallHold  <= 1'b0;
      powerState <= PWR_NORMAL;
      testByte   <= BYTE_ZERO;
    end else if (wrEn) begin
      if (addr == OFS_SEC) begin
        oneInstr  <= wrData[ONE_INSTR_POS];
        stallHold <= wrData[STALL_POS];
      end
      if (addr == OFS_PWR) begin
        powerState <= wrData[1:0];
      end
      if (addr == OFS_TEST) begin
        testByte <= wrData;
      end
    end
  end

  assign shutdown = (powerState == PWR_SHUTDOWN);

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_soft_write;
    wrEn && (addr == OFS_PRI) && wrData[SRST_UP_POS] && wrData[SRST_LO_POS];
  endsequence

  sequence s_defaults;
    !oneInstr && !stallHold && (powerState == PWR_NORMAL) && (testByte == BYTE_ZERO)
      && softResetPulse;
  endsequence

  property p_soft_reset;
    s_soft_write |=> s_defaults ##1 !softResetPulse;
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("soft reset lost");

  property p_half_reset;
    wrEn && (addr == OFS_PRI) && (wrData[SRST_UP_POS] != wrData[SRST_LO_POS])
      |=> !softResetPulse && $stable(testByte);
  endproperty
  a_half_reset: assert property (p_half_reset) else $error("single bit reset");

  sequence s_stream_byte;
    byteDone && !oneInstr && !csIdle;
  endsequence

  property p_decrement;
    s_stream_byte |=> (addr == $past(addr) - ADDR_STEP) && (state == ST_DATA);
  endproperty
  a_decrement: assert property (p_decrement) else $error("address not stepped down");

  property p_one_instr;
    byteDone && oneInstr && !csIdle |=> (state == ST_HOLD) [*2];
  endproperty
  a_one_instr: assert property (p_one_instr) else $error("second byte taken");

  property p_stall;
    wrEn && (addr == OFS_SEC) && !softReset |=> stallHold == $past(wrData[STALL_POS]);
  endproperty
  a_stall: assert property (p_stall) else $error("stall bit not stored");

  property p_fixed_bits;
    instrDone && (instrWord[ADDR_W-1:0] == OFS_SEC) |=> !readShift[COMPACT_POS];
  endproperty
  a_fixed_bits: assert property (p_fixed_bits) else $error("fixed bit moved");
  property p_dir_bits;
    instrDone && (instrWord[ADDR_W-1:0] == OFS_PRI)
      |=> !readShift[ADDR_DIR_POS] && readShift[PIN_GATE_POS];
  endproperty
  a_dir_bits: assert property (p_dir_bits) else $error("direction bit moved");
  property p_power;
    wrEn && (addr == OFS_PWR) && !softReset
      |=> (powerState == $past(wrData[1:0])) && (shutdown == (powerState == PWR_SHUTDOWN));
  endproperty
  a_power: assert property (p_power) else $error("power field wrong");
  property p_ident;
    instrDone && (instrWord[ADDR_W-1:0] == OFS_PART_HI)
      |=> (readShift == PART_CODE[15:8]);
  endproperty
  a_ident: assert property (p_ident) else $error("identity bytes wrong");
  property p_grade;
    instrDone && (instrWord[ADDR_W-1:0] == OFS_GRADE)
      |=> (readShift == {GRADE_CODE, REV_CODE});
  endproperty
  a_grade: assert property (p_grade) else $error("grade byte wrong");

  property p_config_gate;
    (state == ST_IDLE) && csAsserted && !cfgMode |=> (state == ST_HOLD) && !misoOe;
  endproperty
  a_config_gate: assert property (p_config_gate) else $error("access outside config");

endmodule

/* File: bench/aic_spi_host.sv */
// serial host model driving the configuration port
`timescale 1ns/1ps
module aic_spi_host
  import aic_pkg::*;
(
  input  wire logic clk,
  input  wire logic misoOut,
  input  wire logic misoOe,
  output logic      sclkPin,
  output logic      csPin_n,
  output logic      mosiPin
);
  // idle: clock low and still, chip select high
  initial begin
    sclkPin = 1'b0;
    csPin_n = 1'b1;
    mosiPin = 1'b0;
  end
  //////////////////////////////////////////////////////////////////////////
  // one sclk half period, well above the sync delay
  task automatic gap();
    repeat (6) @(posedge clk);
    #1;
  endtask
  // instruction then n bytes; read bits gathered msb first
  task automatic xfer(input logic [15:0] instr, input int n, input logic [31:0] wd,
                      output logic [31:0] rd);
    logic [47:0] sh;
    sh = {instr, wd};
    rd = 32'h0;
    @(posedge clk);
    #1;
    csPin_n = 1'b0;
    for (int i = 0; i < 16 + 8 * n; i++) begin
      mosiPin = sh[47-i];
      gap();
      if (i >= 16) rd = {rd[30:0], misoOut & misoOe}; // undriven line reads low
      sclkPin = 1'b1;
      gap();
      sclkPin = 1'b0;
    end
    gap();
    csPin_n = 1'b1;
    mosiPin = ~mosiPin; // released data line flips
    gap();
  endtask
endmodule

/* File: bench/adc_interface_config_regs_tb.sv */
// self-checking bench for the configuration register group
`timescale 1ns/1ps
module adc_interface_config_regs_tb
  import aic_pkg::*;
;
  localparam logic [3:0]  FAM  = 4'h9;     // arbitrary value
  localparam logic [15:0] PART = 16'h5e3b; // arbitrary value
  localparam logic [4:0]  GRD  = 5'h13;    // arbitrary value
  localparam logic [2:0]  REV  = 3'h5;     // arbitrary value
  logic        clk, arst_n, sclkPin, csPin_n, mosiPin, cfgMode;
  logic        misoOut, misoOe, softResetPulse, shutdown;
  logic [1:0]  powerState, pwr;
  logic [7:0]  pri, sec, test;
  logic [31:0] rd, v;
  logic [14:0] addrs [10];
  int          miscompares, samplesChecked, pulses, expPulses;
  // clock
  initial clk = 1'b0;
  always #2 clk = ~clk;
  // count cycles of soft reset pulse
  always @(posedge clk) if (softResetPulse === 1'b1) pulses++;
  //////////////////////////////////////////////////////////////////////////
  aic_config_regs #(.FAMILY_CODE(FAM), .PART_CODE(PART), .GRADE_CODE(GRD), .REV_CODE(REV))
  u_dut (.clk(clk), .arst_n(arst_n), .sclkPin(sclkPin), .csPin_n(csPin_n),
    .mosiPin(mosiPin), .cfgMode(cfgMode), .misoOut(misoOut), .misoOe(misoOe),
    .softResetPulse(softResetPulse), .powerState(powerState), .shutdown(shutdown));
  aic_spi_host u_host (.clk(clk), .misoOut(misoOut), .misoOe(misoOe), .sclkPin(sclkPin),
    .csPin_n(csPin_n), .mosiPin(mosiPin));
  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic closeOut();
    if (miscompares == 0 && samplesChecked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // expected read value from the shadow copy
  function automatic logic [7:0] exp_rd(input logic [14:0] a);
    case (a)
      OFS_PRI:     return pri;
      OFS_SEC:     return sec;
      OFS_PWR:     return {6'h00, pwr};
      OFS_FAMILY:  return {4'h0, FAM};
      OFS_PART_LO: return PART[7:0];
      OFS_PART_HI: return PART[15:8];
      OFS_GRADE:   return {GRD, REV};
      OFS_TEST:    return test;
      default:     return 8'h00;
    endcase
  endfunction
  // single byte write, shadow follows writable bits only
  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    u_host.xfer({1'b0, a}, 1, {d, 24'h0}, rd);
    if (cfgMode) case (a)
      OFS_PRI: begin
        pri = {d[7], 6'h08, d[0]};
        if (d[7] && d[0]) begin
          sec = 8'h00;
          pwr = 2'h0;
          test = 8'h00;
          expPulses++;
        end
      end
      OFS_SEC:  sec = d & 8'hc0;
      OFS_PWR:  pwr = d[1:0];
      OFS_TEST: test = d;
      default: ;
    endcase
  endtask
  task automatic rdk(input logic [14:0] a, input int n, input logic [31:0] e);
    u_host.xfer({1'b1, a}, n, 32'h0, rd);
    chk("read", rd, e);
  endtask
  //////////////////////////////////////////////////////////////////////////
  // watchdog
  initial begin
    repeat (80000) @(posedge clk);
    miscompares++;
    closeOut();
  end
  // main sequence
  initial begin
    arst_n = 1'b0;
    cfgMode = 1'b1;
    pri = PRI_RST;
    sec = 8'h00;
    pwr = 2'h0;
    test = 8'h00;
    addrs = '{15'h0, 15'h1, 15'h2, 15'h3, 15'h4, 15'h5, 15'h6, 15'ha, 15'h7, 15'h7fff};
    void'($urandom(78282));
    repeat (2) @(posedge clk);
    #1 arst_n = 1'b1;
    repeat (4) @(posedge clk);
    chk("powerState", powerState, 2'h0);
    chk("misoOe", misoOe, 1'b0);
    // reset values, then writes to read-only and reserved places
    for (int p = 0; p < 2; p++) begin
      for (int i = 0; i < 10; i++) rdk(addrs[i], 1, exp_rd(addrs[i]));
      wr(OFS_PRI, 8'h7e);
      wr(OFS_SEC, 8'h3f);
      wr(OFS_PWR, 8'hfc);
      for (int i = 3; i < 8; i++) wr(i[14:0], 8'hff);
    end
    // descending streaming, wrap below zero
    rdk(OFS_GRADE, 3, {8'h00, GRD, REV, PART[15:8], PART[7:0]});
    rdk(OFS_PRI, 2, {16'h0, pri, 8'h00});
    u_host.xfer({1'b0, OFS_PWR}, 2, {8'h03, 8'h40, 16'h0}, rd);
    pwr = 2'h3;
    sec = 8'h40;
    rdk(OFS_PWR, 2, {16'h0, 8'h03, 8'h40});
    chk("shutdown", shutdown, 1'b1);
    // one-instruction mode drops later bytes
    wr(OFS_SEC, 8'hc0);
    rdk(OFS_GRADE, 2, {16'h0, GRD, REV, 8'h00});
    u_host.xfer({1'b0, OFS_PWR}, 2, 32'h0, rd);
    pwr = 2'h0;
    rdk(OFS_SEC, 1, 8'hc0);
    chk("powerState", powerState, 2'h0);
    wr(OFS_SEC, 8'h00);
    // every power code with random test bytes
    for (int i = 0; i < 8; i++) begin
      v = $urandom;
      v[1:0] = i[1:0];
      wr(OFS_PWR, v[7:0]);
      wr(OFS_TEST, v[15:8]);
      chk("powerState", powerState, v[1:0]);
      chk("shutdown", shutdown, &v[1:0]);
      rdk(OFS_TEST, 1, v[15:8]);
    end
    // transactions outside configuration mode are ignored
    @(posedge clk);
    #1 cfgMode = 1'b0;
    wr(OFS_TEST, ~test);
    rdk(OFS_TEST, 1, 8'h00);
    cfgMode = 1'b1;
    rdk(OFS_TEST, 1, test);
    // soft reset only with both bits in one write
    wr(OFS_SEC, 8'h40);
    wr(OFS_PRI, 8'h80);
    wr(OFS_PRI, 8'h01);
    chk("pulses", pulses, expPulses);
    rdk(OFS_SEC, 1, 8'h40);
    wr(OFS_PRI, 8'h81);
    chk("pulses", pulses, expPulses);
    chk("powerState", powerState, 2'h0);
    for (int i = 0; i < 8; i++) rdk(addrs[i], 1, exp_rd(addrs[i]));
    closeOut();
  end
endmodule
